/* rtl/scb_pkg.sv */
// Constants for the serial configuration and alignment control bank.
// Assumes one 250 MHz clock; all byte addresses are 15 bits wide.
package scb_pkg;

   // ----------------------------------------------------------------
   // Serial frame layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int HDR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int HDR_RW_BIT = 15;
   localparam logic [4:0] HDR_LAST = 5'h0F;
   localparam logic [4:0] BYTE_LAST = 5'h07;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [14:0] A_SER_CFG = 15'h0000;
   localparam logic [14:0] A_DEV_MODE = 15'h0002;
   localparam logic [14:0] A_MAKER_LO = 15'h000C;
   localparam logic [14:0] A_MAKER_HI = 15'h000D;
   localparam logic [14:0] A_STREAM_CTL = 15'h0010;
   localparam logic [14:0] A_ALIGN_CTL = 15'h0029;
   localparam logic [14:0] A_EDGE_POS0 = 15'h002C;
   localparam logic [14:0] A_EDGE_POS1 = 15'h002D;
   localparam logic [14:0] A_EDGE_POS2 = 15'h002E;

   // ----------------------------------------------------------------
   // Reset values and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] SER_CFG_RST = 8'h30;
   localparam logic [7:0] SER_CFG_STORE = 8'h6F;
   localparam logic [7:0] SER_CFG_RO_ONE = 8'h10;
   localparam int SER_RESTART_BIT = 7;
   localparam int SER_ASCEND_BIT = 5;
   localparam logic [7:0] DEV_MODE_RST = 8'h00;
   localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
   localparam logic [7:0] STREAM_CTL_RST = 8'h00;
   localparam int STREAM_HOLD_BIT = 0;
   localparam logic [7:0] ALIGN_CTL_RST = 8'h80;
   localparam int ALIGN_PROC_BIT = 6;
   localparam int ALIGN_RECV_BIT = 5;
   localparam int ALIGN_FINE_BIT = 4;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // ----------------------------------------------------------------
   // Soft reset timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int RESTART_TIME_NS = 750;
   localparam int RESTART_CYC = (RESTART_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [7:0] RESTART_LAST = 8'(RESTART_CYC - 1);

   typedef enum logic {SCB_HDR, SCB_DATA} scb_phase_t;

endpackage : scb_pkg

/* rtl/scb_serial_engine.sv */
// Four-wire serial shifter: header, write bytes, read bytes.
// Assumes sclk, cs and sdi already synchronous to mclk_i; mode 0.
`timescale 1ns/10ps
module scb_serial_engine
   import scb_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   input wire logic [7:0] rd_byte_i,
   output logic sdo_o,
   output logic hdr_done_o,
   output logic byte_done_o,
   output logic [15:0] shift_in_o
);

   logic sclk_q_r, sclk_q_nxt;
   scb_phase_t phase_r, phase_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [15:0] sh_in_r, sh_in_nxt;
   logic [7:0] sh_out_r, sh_out_nxt;
   logic load_r, load_nxt;
   logic sdo_r, sdo_nxt;
   logic hdr_r, hdr_nxt;
   logic byte_r, byte_nxt;
   logic rise, fall;

   assign rise = sclk_i & ~sclk_q_r & ~cs_n_i;
   assign fall = ~sclk_i & sclk_q_r & ~cs_n_i;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      sclk_q_nxt = sclk_i;
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      sh_in_nxt = sh_in_r;
      sh_out_nxt = sh_out_r;
      load_nxt = load_r;
      sdo_nxt = sdo_r;
      hdr_nxt = 1'b0;
      byte_nxt = 1'b0;
      if (cs_n_i) begin
         phase_nxt = SCB_HDR;
         cnt_nxt = 5'h00;
         load_nxt = 1'b0;
         sdo_nxt = 1'b0;
      end else if (rise) begin
         sh_in_nxt = {sh_in_r[14:0], sdi_i};
         cnt_nxt = 5'(cnt_r + 5'h01);
         case (phase_r)
            SCB_HDR: begin
               if (cnt_r == HDR_LAST) begin
                  hdr_nxt = 1'b1;
                  phase_nxt = SCB_DATA;
                  cnt_nxt = 5'h00;
                  load_nxt = 1'b1;
               end
            end
            SCB_DATA: begin
               if (cnt_r == BYTE_LAST) begin
                  byte_nxt = 1'b1;
                  cnt_nxt = 5'h00;
                  load_nxt = 1'b1;
               end
            end
            default: phase_nxt = SCB_HDR;
         endcase
      end else if (fall) begin
         // Read data only ever leaves on the dedicated output line
         if (load_r) begin
            sh_out_nxt = rd_byte_i;
            sdo_nxt = rd_byte_i[7];
            load_nxt = 1'b0;
         end else begin
            sh_out_nxt = {sh_out_r[6:0], 1'b0};
            sdo_nxt = sh_out_r[6];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sclk_q_r <= 1'b0;
         phase_r <= SCB_HDR;
         cnt_r <= 5'h00;
         sh_in_r <= 16'h0000;
         sh_out_r <= 8'h00;
         load_r <= 1'b0;
         sdo_r <= 1'b0;
         hdr_r <= 1'b0;
         byte_r <= 1'b0;
      end else begin
         sclk_q_r <= sclk_q_nxt;
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         sh_in_r <= sh_in_nxt;
         sh_out_r <= sh_out_nxt;
         load_r <= load_nxt;
         sdo_r <= sdo_nxt;
         hdr_r <= hdr_nxt;
         byte_r <= byte_nxt;
      end
   end

   assign sdo_o = sdo_r;
   assign hdr_done_o = hdr_r;
   assign byte_done_o = byte_r;
   assign shift_in_o = sh_in_r;

endmodule : scb_serial_engine

/* rtl/scb_config_bank.sv */
// Serial configuration bank: interface setup, operating mode, identity,
// streaming address control and alignment input control.
// Assumes host pins are synchronous to mclk_i, each sclk phase >= 3 cycles.
//
// How it works
// - Writing one to restart bit resets all logic and every register.
// - Restart bit is never stored, so it always reads back zero.
// - Restart completes within 750ns; host stays silent meanwhile.
// - Streaming address steps up when ascend bit is 1, else down.
// - Readback flag reads 1; data returns only on the serial output.
// - Mode field: 0 normal, 3 full power-down, resets to 0.
// - Fixed 16-bit maker identity readable at address 0xC.
// - Freeze bit holds the address fixed throughout streaming.
// - Alignment receiver active only while its enable bit is 1.
// - Alignment events acted on only while processor enable is 1.
// - Fine-step bit selects smaller window delay steps.
// - Four-bit delay select chooses the sampling tap, resets to 0.
// - Read-only 24-bit edge-position status is reported.
`timescale 1ns/10ps
module scb_config_bank
   import scb_pkg::*;
#(
   // Arbitrary identity value
   parameter logic [15:0] MAKER_ID = 16'h5A3C
)
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   input wire logic sysref_event_i,
   input wire logic [23:0] align_edge_position_i,
   output logic sdo_o,
   output logic chip_reset_o,
   output logic [1:0] op_mode_o,
   output logic power_down_o,
   output logic align_receiver_enable_o,
   output logic align_processor_enable_o,
   output logic align_window_fine_step_o,
   output logic [3:0] align_delay_select_o,
   output logic align_event_o
);

   logic [14:0] addr_r, addr_nxt;
   logic rw_r, rw_nxt;
   logic [7:0] ser_cfg_r, ser_cfg_nxt;
   logic [7:0] dev_mode_r, dev_mode_nxt;
   logic [7:0] stream_ctl_r, stream_ctl_nxt;
   logic [7:0] align_ctl_r, align_ctl_nxt;
   logic pd_r, pd_nxt;
   logic evt_r, evt_nxt;
   logic restart_r, restart_nxt;
   logic [7:0] rcnt_r, rcnt_nxt;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic wr_en;
   logic restart_req;
   logic eng_rst;
   logic hdr_done, byte_done;
   logic [15:0] shift_in;

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   // Restart holds engine, address and registers as a pin reset would
   assign eng_rst = reset_i | restart_r;

   scb_serial_engine u_engine (
      .mclk_i(mclk_i),
      .rst_i(eng_rst),
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .sdi_i(sdi_i),
      .rd_byte_i(rd_byte),
      .sdo_o(sdo_o),
      .hdr_done_o(hdr_done),
      .byte_done_o(byte_done),
      .shift_in_o(shift_in)
   );

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      case (addr_r)
         // Restart bit never stored; readback flag forced to one
         A_SER_CFG: rd_byte = (ser_cfg_r & SER_CFG_STORE) | SER_CFG_RO_ONE;
         A_DEV_MODE: rd_byte = dev_mode_r;
         A_MAKER_LO: rd_byte = MAKER_ID[7:0];
         A_MAKER_HI: rd_byte = MAKER_ID[15:8];
         A_STREAM_CTL: rd_byte = stream_ctl_r;
         A_ALIGN_CTL: rd_byte = align_ctl_r;
         // Status is read live; a streamed read may mix two samples
         A_EDGE_POS0: rd_byte = align_edge_position_i[7:0];
         A_EDGE_POS1: rd_byte = align_edge_position_i[15:8];
         A_EDGE_POS2: rd_byte = align_edge_position_i[23:16];
         default: rd_byte = UNMAPPED_RD;
      endcase
   end

   assign wr_byte = shift_in[7:0];
   assign wr_en = byte_done & ~rw_r;
   assign restart_req = wr_en & (addr_r == A_SER_CFG)
      & wr_byte[SER_RESTART_BIT];

   // ----------------------------------------------------------------
   // Address tracking
   // ----------------------------------------------------------------
   always_comb begin
      addr_nxt = addr_r;
      rw_nxt = rw_r;
      if (hdr_done) begin
         addr_nxt = shift_in[14:0];
         rw_nxt = shift_in[HDR_RW_BIT];
      // Address moves after every byte, read or write; freeze wins
      end else if (byte_done && !stream_ctl_r[STREAM_HOLD_BIT]) begin
         if (ser_cfg_r[SER_ASCEND_BIT])
            addr_nxt = 15'(addr_r + 15'h0001);
         else
            addr_nxt = 15'(addr_r - 15'h0001);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (eng_rst) begin
         addr_r <= 15'h0000;
         rw_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         rw_r <= rw_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_comb begin
      ser_cfg_nxt = ser_cfg_r;
      dev_mode_nxt = dev_mode_r;
      stream_ctl_nxt = stream_ctl_r;
      align_ctl_nxt = align_ctl_r;
      if (wr_en) begin
         // Reserved bits are kept as written
         case (addr_r)
            A_SER_CFG: ser_cfg_nxt = wr_byte & SER_CFG_STORE;
            A_DEV_MODE: dev_mode_nxt = wr_byte;
            A_STREAM_CTL: stream_ctl_nxt = wr_byte;
            A_ALIGN_CTL: align_ctl_nxt = wr_byte;
            default: ser_cfg_nxt = ser_cfg_r;
         endcase
      end
      // Taken from the next mode so the flag never lags the field
      pd_nxt = (dev_mode_nxt[1:0] == MODE_POWER_DOWN);
      // Events pass only with both receiver and processor on
      evt_nxt = sysref_event_i & align_ctl_r[ALIGN_RECV_BIT]
         & align_ctl_r[ALIGN_PROC_BIT];
   end

   always_ff @(posedge mclk_i) begin
      if (eng_rst) begin
         ser_cfg_r <= SER_CFG_RST & SER_CFG_STORE;
         dev_mode_r <= DEV_MODE_RST;
         stream_ctl_r <= STREAM_CTL_RST;
         align_ctl_r <= ALIGN_CTL_RST;
         pd_r <= 1'b0;
         evt_r <= 1'b0;
      end else begin
         ser_cfg_r <= ser_cfg_nxt;
         dev_mode_r <= dev_mode_nxt;
         stream_ctl_r <= stream_ctl_nxt;
         align_ctl_r <= align_ctl_nxt;
         pd_r <= pd_nxt;
         evt_r <= evt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Soft restart timer
   // ----------------------------------------------------------------
   always_comb begin
      restart_nxt = restart_r;
      rcnt_nxt = rcnt_r;
      // Fixed settle time; the host must stay silent until it ends
      if (restart_req) begin
         restart_nxt = 1'b1;
         rcnt_nxt = RESTART_LAST;
      end else if (restart_r) begin
         if (rcnt_r == 8'h00)
            restart_nxt = 1'b0;
         else
            rcnt_nxt = 8'(rcnt_r - 8'h01);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         restart_r <= 1'b0;
         rcnt_r <= 8'h00;
      end else begin
         restart_r <= restart_nxt;
         rcnt_r <= rcnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // All outputs are plain register bits, no logic on the way out
   assign chip_reset_o = restart_r;
   assign op_mode_o = dev_mode_r[1:0];
   assign power_down_o = pd_r;
   assign align_receiver_enable_o = align_ctl_r[ALIGN_RECV_BIT];
   assign align_processor_enable_o = align_ctl_r[ALIGN_PROC_BIT];
   assign align_window_fine_step_o = align_ctl_r[ALIGN_FINE_BIT];
   assign align_delay_select_o = align_ctl_r[3:0];
   assign align_event_o = evt_r;

endmodule : scb_config_bank

/* tb/scb_config_bank_assertions.sv */
// Port checker for the serial configuration bank.
// Assumes the single mclk_i domain and the package constants.
`timescale 1ns/10ps
module scb_config_bank_chk
   import scb_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sysref_event_i,
   input wire logic sdo_o,
   input wire logic chip_reset_o,
   input wire logic [1:0] op_mode_o,
   input wire logic power_down_o,
   input wire logic align_receiver_enable_o,
   input wire logic align_processor_enable_o,
   input wire logic [3:0] align_delay_select_o,
   input wire logic align_event_o
);
   // ----------
   // Restart length count
   // ----------
   logic [7:0] run_r;
   logic [7:0] run_nxt;
   always_comb begin
      run_nxt = chip_reset_o ? run_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge mclk_i) begin
      run_r <= reset_i ? 8'h00 : run_nxt;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_mode_power_down: assert property (
      power_down_o == (op_mode_o == MODE_POWER_DOWN))
      else $error("power down differs from mode field");
   a_event_gated: assert property (
      align_event_o == ($past(sysref_event_i) &&
      $past(align_receiver_enable_o) && $past(align_processor_enable_o)))
      else $error("alignment event not gated by enables");
   a_restart_bound: assert property (
      chip_reset_o |-> run_r <= RESTART_LAST)
      else $error("restart lasts too long");
   a_restart_end: assert property (
      $fell(chip_reset_o) |-> run_r == RESTART_LAST + 8'h01 &&
      op_mode_o == 2'h0 && align_delay_select_o == 4'h0)
      else $error("restart ended early or left state");
   a_restart_quiet: assert property (
      chip_reset_o && $past(chip_reset_o) |-> !sdo_o && !power_down_o)
      else $error("outputs active during restart");
   a_sdo_idle: assert property (
      cs_n_i && $past(cs_n_i) |-> !sdo_o)
      else $error("serial output active while deselected");
   a_cfg_by_host: assert property (
      $changed({op_mode_o, align_receiver_enable_o, align_delay_select_o,
      align_processor_enable_o}) |-> !$past(cs_n_i) || chip_reset_o)
      else $error("configuration changed without host access");
   a_restart_cause: assert property (
      $rose(chip_reset_o) |-> !$past(cs_n_i, 2) && $past(sclk_i, 2))
      else $error("restart without a serial write");
endmodule : scb_config_bank_chk

bind scb_config_bank scb_config_bank_chk u_chk (
   .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
   .sysref_event_i(sysref_event_i), .sdo_o(sdo_o),
   .chip_reset_o(chip_reset_o), .op_mode_o(op_mode_o),
   .power_down_o(power_down_o),
   .align_receiver_enable_o(align_receiver_enable_o),
   .align_processor_enable_o(align_processor_enable_o),
   .align_delay_select_o(align_delay_select_o),
   .align_event_o(align_event_o));

/* tb/scb_host_model.sv */
// Host serial master: header then data bytes, mode 0, MSB first.
// Assumes mclk_i at 250 MHz; each serial clock phase lasts 4 cycles.
`timescale 1ns/10ps
module scb_host_model (
   input wire logic mclk_i,
   input wire logic sdo_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // Post holds select low after the last bit, for a restart wait
   task frame(input logic rd, input logic [14:0] adr, input int n,
              input logic [31:0] wd, input int post,
              output logic [31:0] rdv);
      logic [47:0] sh;
      sh = {rd, adr, wd};
      rdv = 32'h0;
      @(posedge mclk_i) #1 cs_n_o = 1'b0;
      for (int i = 0; i < 16 + 8 * n; i++) begin
         sclk_o = 1'b0;
         sdi_o = sh[47];
         sh = sh << 1;
         repeat (4) @(posedge mclk_i);
         #1 sclk_o = 1'b1;
         if (i >= 16) begin
            rdv = {rdv[30:0], sdo_i};
         end
         repeat (4) @(posedge mclk_i);
         // Pins move just after the edge, never on it
         #1;
      end
      repeat (post) begin
         @(posedge mclk_i);
         #1;
      end
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask : frame
endmodule : scb_host_model

/* tb/scb_config_bank_tb.sv */
// Testbench for the serial configuration bank.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
module scb_config_bank_tb;
   import scb_pkg::*;
   localparam logic [15:0] ID = 16'h5A3C; // Arbitrary value
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ev_i = 1'b0;
   logic sclk, cs_n, sdi, sdo, crst, pd, ar, ap, af, ev_o;
   logic [1:0] mode;
   logic [3:0] dsel;
   logic [31:0] rv;
   logic [23:0] pos = 24'hA5C33C;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   always #2 mclk_i = ~mclk_i;
   scb_config_bank #(.MAKER_ID(ID)) uut (.mclk_i(mclk_i),
      .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
      .sysref_event_i(ev_i), .align_edge_position_i(pos),
      .sdo_o(sdo), .chip_reset_o(crst), .op_mode_o(mode),
      .power_down_o(pd), .align_receiver_enable_o(ar),
      .align_processor_enable_o(ap), .align_window_fine_step_o(af),
      .align_delay_select_o(dsel), .align_event_o(ev_o));
   scb_host_model h (.mclk_i(mclk_i), .sdo_i(sdo), .sclk_o(sclk),
      .cs_n_o(cs_n), .sdi_o(sdi));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [14:0] a, input logic [7:0] d);
      h.frame(1'b0, a, 1, {d, 24'h0}, 0, rv);
   endtask : wr
   task rd(input logic [14:0] a, input int n, input logic [31:0] e);
      h.frame(1'b1, a, n, 32'h0, 0, rv);
      chk(rv, e);
   endtask : rd
   task pulse(input logic exp);
      @(posedge mclk_i) #1 ev_i = 1'b1;
      @(posedge mclk_i) #1 ev_i = 1'b0;
      chk(ev_o, exp);
   endtask : pulse
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 50000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      #1 reset_i = 1'b0;
      chk({sdo, crst, mode, pd, ar, ap, af, dsel, ev_o}, 0);
      rd(A_SER_CFG, 1, 32'h30);
      rd(A_DEV_MODE, 1, 32'h00);
      rd(A_STREAM_CTL, 1, 32'h00);
      rd(A_ALIGN_CTL, 1, 32'h80);
      rd(15'h0003, 1, {24'h0, UNMAPPED_RD});
      $display("reset values done");
      rd(A_MAKER_LO, 2, {16'h0, ID[7:0], ID[15:8]});
      wr(A_MAKER_LO, 8'hFF);
      wr(A_SER_CFG, 8'h00);
      rd(A_SER_CFG, 1, 32'h10);
      rd(A_MAKER_HI, 2, {16'h0, ID[15:8], ID[7:0]});
      wr(A_STREAM_CTL, 8'h01);
      rd(A_MAKER_LO, 3, {8'h0, ID[7:0], ID[7:0], ID[7:0]});
      wr(A_STREAM_CTL, 8'h00);
      wr(A_SER_CFG, 8'h30);
      $display("streaming done");
      for (int m = 0; m < 4; m++) begin
         wr(A_DEV_MODE, 8'(m));
         chk({mode, pd}, {m[1:0], m == 3});
      end
      wr(A_ALIGN_CTL, 8'hA0);
      pulse(1'b0);
      rd(A_EDGE_POS0, 3, 32'h003CC3A5);
      wr(A_ALIGN_CTL, 8'hF9);
      chk({ar, ap, af, dsel}, 7'h79);
      pulse(1'b1);
      pos = 24'h5AF00F;
      rd(A_EDGE_POS2, 1, 32'h5A);
      $display("mode and alignment done");
      wr(A_SER_CFG, 8'h00);
      fork
         h.frame(1'b0, A_SER_CFG, 1, 32'h80000000, 200, rv);
         begin
            repeat (300) @(posedge mclk_i);
            #1 chk(crst, 1'b1);
         end
      join
      chk({crst, mode, pd, ar, ap, af, dsel}, 0);
      rd(A_SER_CFG, 1, 32'h30);
      rd(A_DEV_MODE, 1, 32'h00);
      rd(A_ALIGN_CTL, 1, 32'h80);
      $display("restart done");
      wrap_up();
   end
endmodule : scb_config_bank_tb
